// >>> core/dpram_host.sv
`include "dpram_host_map.svh"

// Behaviour
// - Slave busy input high allows operation; low blocks writes on that port.
// - Hold address and enable until busy settles before starting write strobe.
// - Use exactly one master when widening the data path.
// - Depth expansion ANDs active-low busy outputs into array busy.
// - Flags active low: write zero requests, same port writes one releases.
module dpram_host
   import dpram_host_pkg::*;
(
   // Clock and reset
   input  wire logic                 clock_i,
   input  wire logic                 sys_rst_i,
   // User command
   input  wire logic                 cmd_valid_i,
   input  wire cmd_kind_t            cmd_kind_i,
   input  wire logic [`ADDR_W-1:0]   cmd_addr_i,
   input  wire logic [`DATA_W-1:0]   cmd_wdata_i,
   output logic                      cmd_ready_o,
   // User response
   output logic                      rsp_valid_o,
   output logic [`DATA_W-1:0]        rsp_rdata_o,
   output logic                      rsp_busy_o,
   output logic                      rsp_token_o,
   // User configuration
   input  wire logic                 master_mode_i,
   input  wire logic                 write_inhibit_i,
   output logic                      mailbox_pending_o,
   // Device port pins
   output logic                      mem_enable_n_o,
   output logic                      flag_space_select_n_o,
   output logic                      rw_n_o,
   output logic                      out_enable_n_o,
   output logic [`ADDR_W-1:0]        addr_o,
   input  wire logic [`DATA_W-1:0]   data_i,
   output logic [`DATA_W-1:0]        data_o,
   output logic                      data_oe_o,
   input  wire logic                 busy_n_i,
   output logic                      busy_n_o,
   output logic                      busy_oe_o,
   output logic                      ms_select_o,
   input  wire logic                 mailbox_irq_n_i
);
   host_state_t        state_r;
   cmd_kind_t          kind_r;
   logic               tmr_load;
   logic [`TMR_W-1:0]  tmr_count;
   logic               tmr_done;
   logic               is_write;
   logic               is_sem;
   logic               busy_hit;

   assign is_write = (kind_r == CMD_MEM_WRITE) || (kind_r == CMD_SEM_WRITE);
   assign is_sem   = (kind_r == CMD_SEM_READ) || (kind_r == CMD_SEM_WRITE);
   // Master busy low stalls the access until the other side is done
   assign busy_hit = ms_select_o && !busy_n_i;

   access_timer u_timer (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .load_i    (tmr_load),
      .count_i   (tmr_count),
      .done_o    (tmr_done)
   );

   // -------------------------------------------------------------------------
   // Interval selection
   // -------------------------------------------------------------------------
   always_comb begin
      tmr_load  = 1'b0;
      tmr_count = '0;
      case (state_r)
         ST_IDLE: begin
            tmr_load  = cmd_valid_i && cmd_ready_o;
            tmr_count = `TMR_W'(`SETTLE_CYC);
         end
         ST_SETTLE: begin
            tmr_load  = tmr_done && !busy_hit;
            tmr_count = is_write ? `TMR_W'(`WPULSE_CYC) : `TMR_W'(`RACCESS_CYC);
         end
         ST_STROBE: begin
            tmr_load  = tmr_done;
            tmr_count = `TMR_W'(`WHOLD_CYC);
         end
         default: begin
            tmr_load  = 1'b0;
            tmr_count = '0;
         end
      endcase
   end

   // -------------------------------------------------------------------------
   // Access sequencer
   // -------------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_r <= ST_IDLE;
         kind_r  <= CMD_MEM_READ;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (cmd_valid_i && cmd_ready_o) begin
                  kind_r  <= cmd_kind_i;
                  state_r <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               if (tmr_done && !busy_hit) begin
                  state_r <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               if (tmr_done) begin
                  state_r <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (tmr_done) begin
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Enables, address and data pins
   // -------------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         mem_enable_n_o        <= 1'b1;
         flag_space_select_n_o <= 1'b1;
         addr_o                <= `ADDR_RST;
         data_o                <= `DATA_RST;
         data_oe_o             <= 1'b0;
      end else if (state_r == ST_IDLE && cmd_valid_i && cmd_ready_o) begin
         if (cmd_kind_i == CMD_SEM_READ || cmd_kind_i == CMD_SEM_WRITE) begin
            flag_space_select_n_o <= 1'b0;
            addr_o <= {{(`ADDR_W-`SEM_SEL_W){1'b0}}, cmd_addr_i[`SEM_SEL_W-1:0]};
            data_o <= cmd_wdata_i[0] ? `DATA_ONES : `DATA_ZERO;
         end else begin
            mem_enable_n_o <= 1'b0;
            addr_o         <= cmd_addr_i;
            data_o         <= cmd_wdata_i;
         end
         data_oe_o <= (cmd_kind_i == CMD_MEM_WRITE) || (cmd_kind_i == CMD_SEM_WRITE);
      end else if (state_r == ST_HOLD && tmr_done) begin
         // Both enables high again: port drops to standby
         mem_enable_n_o        <= 1'b1;
         flag_space_select_n_o <= 1'b1;
         data_oe_o             <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Strobes
   // -------------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         rw_n_o         <= 1'b1;
         out_enable_n_o <= 1'b1;
      end else if (state_r == ST_SETTLE && tmr_done && !busy_hit) begin
         rw_n_o         <= !is_write;
         out_enable_n_o <= is_write;
      end else if (state_r == ST_STROBE && tmr_done) begin
         // Dropping output enable lets the next semaphore read relatch
         rw_n_o         <= 1'b1;
         out_enable_n_o <= 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Handshake and response
   // -------------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cmd_ready_o <= 1'b0;
         rsp_valid_o <= 1'b0;
         rsp_rdata_o <= `DATA_RST;
         rsp_busy_o  <= 1'b0;
         rsp_token_o <= 1'b0;
      end else begin
         rsp_valid_o <= state_r == ST_HOLD && tmr_done;
         if (state_r == ST_IDLE && cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o <= 1'b0;
            rsp_busy_o  <= 1'b0;
         end else if (state_r == ST_IDLE) begin
            cmd_ready_o <= 1'b1;
         end
         if (state_r == ST_SETTLE && busy_hit) begin
            rsp_busy_o <= 1'b1;
         end
         if (state_r == ST_SETTLE && is_write && !ms_select_o && write_inhibit_i) begin
            rsp_busy_o <= 1'b1;
         end
         if (state_r == ST_STROBE && tmr_done && !is_write) begin
            rsp_rdata_o <= data_i;
            // Flag reads back replicated; all zeros means this side holds it
            rsp_token_o <= is_sem && (data_i == `DATA_ZERO);
         end
      end
   end

   // -------------------------------------------------------------------------
   // Busy pin, mode select and mailbox
   // -------------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ms_select_o       <= 1'b0;
         busy_n_o          <= 1'b1;
         busy_oe_o         <= 1'b0;
         mailbox_pending_o <= 1'b0;
      end else begin
         ms_select_o       <= master_mode_i;
         busy_oe_o         <= !master_mode_i;
         busy_n_o          <= !write_inhibit_i;
         mailbox_pending_o <= !mailbox_irq_n_i;
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   logic [7:0] sel_cnt_r;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         sel_cnt_r <= '0;
      end else if (mem_enable_n_o && flag_space_select_n_o) begin
         sel_cnt_r <= '0;
      end else if (sel_cnt_r != 8'hff) begin
         sel_cnt_r <= sel_cnt_r + 8'h01;
      end
   end

   standby_after_rsp_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      rsp_valid_o |-> mem_enable_n_o && flag_space_select_n_o)
      else $error("Port not in standby after access");
   write_settle_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      $fell(rw_n_o) |-> sel_cnt_r >= 8'(`SETTLE_CYC))
      else $error("Write strobe before busy settle time");
   no_strobe_busy_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      ($fell(rw_n_o) || $fell(out_enable_n_o)) && ms_select_o |-> $past(busy_n_i))
      else $error("Strobe started while master busy low");
   busy_dir_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      $rose(busy_oe_o) |-> !ms_select_o ##0 busy_n_o == !$past(write_inhibit_i))
      else $error("Busy pin direction or level wrong");
   sem_addr_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !flag_space_select_n_o |-> addr_o[`ADDR_W-1:`SEM_SEL_W] == '0)
      else $error("Semaphore access with high address bits set");
   sem_data_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !flag_space_select_n_o && data_oe_o |-> data_o == `DATA_ZERO || data_o == `DATA_ONES)
      else $error("Semaphore write data not uniform");
   one_space_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !(!mem_enable_n_o && !flag_space_select_n_o))
      else $error("Memory and semaphore selected together");
   wpulse_len_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      $fell(rw_n_o) |-> !rw_n_o [*5] ##1 rw_n_o)
      else $error("Write pulse length wrong");
   rsp_pulse_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      rsp_valid_o |=> !rsp_valid_o && cmd_ready_o)
      else $error("Response not a single pulse");

   sem_write_c: cover property (@(posedge clock_i) disable iff (sys_rst_i)
      $fell(rw_n_o) && !flag_space_select_n_o);
   mem_read_c: cover property (@(posedge clock_i) disable iff (sys_rst_i)
      rsp_valid_o && !rsp_busy_o && $past(kind_r == CMD_MEM_READ));
   busy_stall_c: cover property (@(posedge clock_i) disable iff (sys_rst_i)
      state_r == ST_SETTLE && busy_hit ##1 state_r == ST_SETTLE);
   slave_inhibit_c: cover property (@(posedge clock_i) disable iff (sys_rst_i)
      rsp_valid_o && rsp_busy_o && !ms_select_o);
endmodule

// >>> core/dpram_host_map.svh
`ifndef DPRAM_HOST_MAP_SVH
`define DPRAM_HOST_MAP_SVH

// Pin and timer widths
`define ADDR_W        13
`define DATA_W        8
`define SEM_SEL_W     3
`define TMR_W         4

// Clock period and access timing in ns
`define T_CLK_NS      8
`define T_SETTLE_NS   45
`define T_WPULSE_NS   40
`define T_RACCESS_NS  55
`define T_WHOLD_NS    25

// Cycle counts, least times rounded up
`define SETTLE_CYC    ((`T_SETTLE_NS + `T_CLK_NS - 1) / `T_CLK_NS)
`define WPULSE_CYC    ((`T_WPULSE_NS + `T_CLK_NS - 1) / `T_CLK_NS)
`define RACCESS_CYC   ((`T_RACCESS_NS + `T_CLK_NS - 1) / `T_CLK_NS)
`define WHOLD_CYC     ((`T_WHOLD_NS + `T_CLK_NS - 1) / `T_CLK_NS)

// Reset values of pin drivers and semaphore data patterns
`define ADDR_RST      13'h0000
`define DATA_RST      8'h00
`define DATA_ONES     8'hff
`define DATA_ZERO     8'h00

`endif

// >>> core/dpram_host_pkg.sv
package dpram_host_pkg;
   typedef enum logic [1:0] {
      CMD_MEM_READ,
      CMD_MEM_WRITE,
      CMD_SEM_READ,
      CMD_SEM_WRITE
   } cmd_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETTLE,
      ST_STROBE,
      ST_HOLD
   } host_state_t;
endpackage

// >>> core/access_timer.sv
`include "dpram_host_map.svh"

module access_timer (
   // Clock and reset
   input  wire logic                clock_i,
   input  wire logic                sys_rst_i,
   // Control
   input  wire logic                load_i,
   input  wire logic [`TMR_W-1:0]   count_i,
   output logic                     done_o
);
   logic [`TMR_W-1:0] cnt_r;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cnt_r <= '0;
      end else if (load_i) begin
         cnt_r <= count_i;
      end else if (cnt_r > `TMR_W'(1)) begin
         cnt_r <= cnt_r - `TMR_W'(1);
      end
   end

   // Expiry holds until the next load, so a stalled owner can wait it out
   assign done_o = (cnt_r == `TMR_W'(1));
endmodule

// >>> tb/dpram_device_model.sv
module dpram_device_model (
   // Clock
   input  wire logic        clock_i,
   // Port pins from host
   input  wire logic        ce_n_i,
   input  wire logic        sem_n_i,
   input  wire logic        rw_n_i,
   input  wire logic        oe_n_i,
   input  wire logic [12:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        busy_host_n_i,
   input  wire logic        busy_oe_i,
   input  wire logic        ms_sel_i,
   // Bench control
   input  wire logic        collide_i,
   // Pins to host, and far-port interrupt to bench
   output logic [7:0]       data_o,
   output logic             busy_n_o,
   output logic             irq_n_o,
   output logic             other_irq_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem_r [0:8191];
   logic [1:0] own_r [0:7];
   logic       pend_r [1:2][0:7];
   logic       irq_r = 1'b0;
   logic       oirq_r = 1'b0;
   logic [7:0] last_r = 8'h00;
   logic [7:0] rd;
   logic       drv;
   logic       inhibit;
   initial for (int i = 0; i < 8; i++) begin
      own_r[i] = 2'd0;
      pend_r[1][i] = 1'b0;
      pend_r[2][i] = 1'b0;
   end
   // Owner 1 is host, 2 is far port
   task automatic sem_wr(input logic [1:0] me, input logic [2:0] i, input logic b);
      logic [1:0] th;
      th = 2'd3 - me;
      if (!b) begin
         if (own_r[i] == 2'd0) own_r[i] = me;
         else if (own_r[i] != me) pend_r[me][i] = 1'b1;
      end else begin
         pend_r[me][i] = 1'b0;
         if (own_r[i] == me) begin
            own_r[i] = pend_r[th][i] ? th : 2'd0;
            pend_r[th][i] = 1'b0;
         end
      end
   endtask
   task automatic other_write(input logic [12:0] a, input logic [7:0] d);
      mem_r[a] = d;
      if (a == 13'h1ffe) irq_r = 1'b1;
   endtask
   task automatic other_read_top();
      oirq_r = 1'b0;
   endtask
   task automatic other_sem(input logic [2:0] i, input logic b);
      sem_wr(2'd2, i, b);
   endtask
   assign busy_n_o = busy_oe_i ? busy_host_n_i : !collide_i;
   assign inhibit = ms_sel_i ? collide_i : (busy_oe_i && !busy_host_n_i);
   assign rd = !sem_n_i ? {8{own_r[addr_i[2:0]] != 2'd1}} : mem_r[addr_i];
   assign drv = !oe_n_i && rw_n_i && (!ce_n_i || !sem_n_i);
   assign data_o = drv ? rd : ~last_r;
   assign irq_n_o = !irq_r;
   assign other_irq_n_o = !oirq_r;
   always @(posedge clock_i) if (drv) last_r <= rd;
   always @(posedge rw_n_i) if (!inhibit) begin
      if (!ce_n_i) mem_r[addr_i] = wdata_i;
      if (!ce_n_i && addr_i == 13'h1fff) oirq_r = 1'b1;
      if (!sem_n_i) sem_wr(2'd1, addr_i[2:0], wdata_i[0]);
   end
   always @(posedge oe_n_i) if (!ce_n_i && addr_i == 13'h1ffe) irq_r = 1'b0;
endmodule

// >>> tb/dpram_host_bench.sv
`include "dpram_host_map.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; $display("BAD %0t mismatch", $time); end end
module dpram_host_bench
   import dpram_host_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 0, sys_rst_i = 1, cmd_valid_i = 0, master_mode_i = 1, write_inhibit_i = 0, collide = 0;
   cmd_kind_t cmd_kind_i = CMD_MEM_READ;
   logic [12:0] cmd_addr_i = 13'h0000;
   logic [7:0] cmd_wdata_i = 8'h00, data_i, r_data, exp_d [0:5];
   logic [12:0] exp_a [0:5];
   logic cmd_ready_o, rsp_valid_o, rsp_busy_o, rsp_token_o, mailbox_pending_o, ce_n, sem_n, rw_n, oe_n;
   logic data_oe_o, busy_n_i, busy_n_o, busy_oe_o, ms_sel, irq_n, oirq_n, r_busy, r_tok;
   logic [12:0] addr_o;
   logic [7:0] data_o;
   integer seed = 32'h1d4a3358, bad_count = 0, n_compared = 0, cyc = 0;
   dpram_host dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
      .cmd_kind_i(cmd_kind_i), .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o),
      .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(r_data), .rsp_busy_o(rsp_busy_o), .rsp_token_o(rsp_token_o),
      .master_mode_i(master_mode_i), .write_inhibit_i(write_inhibit_i), .mailbox_pending_o(mailbox_pending_o),
      .mem_enable_n_o(ce_n), .flag_space_select_n_o(sem_n), .rw_n_o(rw_n), .out_enable_n_o(oe_n),
      .addr_o(addr_o), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .busy_n_i(busy_n_i),
      .busy_n_o(busy_n_o), .busy_oe_o(busy_oe_o), .ms_select_o(ms_sel), .mailbox_irq_n_i(irq_n));
   dpram_device_model model_u (.clock_i(clock_i), .ce_n_i(ce_n), .sem_n_i(sem_n), .rw_n_i(rw_n),
      .oe_n_i(oe_n), .addr_i(addr_o), .wdata_i(data_o), .busy_host_n_i(busy_n_o), .busy_oe_i(busy_oe_o),
      .ms_sel_i(ms_sel), .collide_i(collide), .data_o(data_i), .busy_n_o(busy_n_i), .irq_n_o(irq_n),
      .other_irq_n_o(oirq_n));
   initial forever #4 clock_i = ~clock_i;
   task automatic tally_and_finish();
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 10000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic cmd(input cmd_kind_t k, input logic [12:0] a, input logic [7:0] d);
      int n;
      n = 0;
      while (cmd_ready_o !== 1'b1 && n < 100) begin @(posedge clock_i); #1; n++; end
      cmd_valid_i = 1;
      cmd_kind_i = k;
      cmd_addr_i = a;
      cmd_wdata_i = d;
      @(posedge clock_i); #1;
      cmd_valid_i = 0;
      `CHK(data_oe_o, (k == CMD_MEM_WRITE) || (k == CMD_SEM_WRITE))
      n = 0;
      while (rsp_valid_o !== 1'b1 && n < 200) begin @(posedge clock_i); #1; n++; end
      `CHK(rsp_valid_o, 1'b1)
      `CHK({ce_n, sem_n}, 2'b11)
      r_busy = rsp_busy_o;
      r_tok = rsp_token_o;
   endtask
   initial begin
      repeat (10) @(posedge clock_i);
      #1 sys_rst_i = 0;
      for (int i = 0; i < 6; i++) begin
         exp_a[i] = (i < 2) ? 13'h1ffe + i : {i[2:0], 10'($random(seed))};
         exp_d[i] = 8'($random(seed));
         cmd(CMD_MEM_WRITE, exp_a[i], exp_d[i]);
      end
      for (int i = 0; i < 6; i++) begin
         cmd(CMD_MEM_READ, exp_a[i], 8'h00);
         `CHK(r_data, exp_d[i])
      end
      `CHK(oirq_n, 1'b0)
      model_u.other_read_top();
      #1;
      `CHK(oirq_n, 1'b1)
      $display("test memory done");
      model_u.other_write(13'h1ffe, 8'h5a);
      repeat (3) @(posedge clock_i); #1;
      `CHK(mailbox_pending_o, 1'b1)
      cmd(CMD_MEM_READ, 13'h1ffe, 8'h00);
      `CHK(r_data, 8'h5a)
      repeat (3) @(posedge clock_i); #1;
      `CHK(mailbox_pending_o, 1'b0)
      $display("test mailbox done");
      for (int i = 0; i < 8; i++) begin
         cmd(CMD_SEM_WRITE, {10'($random(seed)), i[2:0]}, 8'hfe);
         cmd(CMD_SEM_READ, {10'($random(seed)), i[2:0]}, 8'h00);
         `CHK({r_tok, r_data}, 9'h100)
         model_u.other_sem(i[2:0], 1'b0);
         cmd(CMD_SEM_WRITE, {10'($random(seed)), i[2:0]}, 8'h01);
         cmd(CMD_SEM_WRITE, {10'($random(seed)), i[2:0]}, 8'h00);
         cmd(CMD_SEM_READ, {10'($random(seed)), i[2:0]}, 8'h00);
         `CHK({r_tok, r_data}, 9'h0ff)
         model_u.other_sem(i[2:0], 1'b1);
         cmd(CMD_SEM_READ, {10'($random(seed)), i[2:0]}, 8'h00);
         `CHK(r_data, 8'h00)
         cmd(CMD_SEM_WRITE, {10'($random(seed)), i[2:0]}, 8'h01);
      end
      $display("test semaphore done");
      master_mode_i = 0;
      write_inhibit_i = 1;
      repeat (3) @(posedge clock_i); #1;
      `CHK({busy_oe_o, busy_n_o, ms_sel}, 3'b100)
      cmd(CMD_MEM_WRITE, exp_a[2], 8'hc3);
      `CHK(r_busy, 1'b1)
      write_inhibit_i = 0;
      cmd(CMD_MEM_READ, exp_a[2], 8'h00);
      `CHK(r_data, exp_d[2])
      cmd(CMD_MEM_WRITE, exp_a[2], 8'hc3);
      cmd(CMD_MEM_READ, exp_a[2], 8'h00);
      `CHK(r_data, 8'hc3)
      master_mode_i = 1;
      repeat (3) @(posedge clock_i); #1;
      `CHK(busy_oe_o, 1'b0)
      $display("test slave done");
      for (int k = 0; k < 2; k++) begin
         collide = 1;
         fork
            cmd(k ? CMD_MEM_READ : CMD_MEM_WRITE, 13'h0200, 8'h3c);
            begin repeat (12) @(posedge clock_i); #1 collide = 0; end
         join
         `CHK(r_busy, 1'b1)
         `CHK(r_data, k ? 8'h3c : 8'hc3)
      end
      $display("test busy done");
      tally_and_finish();
   end
endmodule
